// ### tb.sv
// Self-checking bench of the two-channel capture/compare timer
`timescale 1ns/1ns
module tb;
  import tct_pkg::*;
  logic clk, rst;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, uirq;
  logic [31:0] wdata, rdata, v, w;
  logic [3:0] wstrb, trg;
  logic [1:0] bresp, rresp, rs, bs, pin, cout, coe, cirq, dreq;
  int errors, compares, cycles, hi, tg, ne, dma0, dma1;

  tct_timer uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .channel_input_pin(pin), .internal_trigger_input(trg),
    .channel_out(cout), .channel_out_en(coe), .channel_irq(cirq),
    .update_irq(uirq), .channel_dma_req(dreq));
  tct_src_model src (.clk(clk), .pin(pin), .trg(trg));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cycle limit and request pulse counting
  always @(posedge clk) begin
    cycles++;
    dma0 += (dreq[0] === 1'b1);
    dma1 += (dreq[1] === 1'b1);
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  task final_report;
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task chkr(input logic [31:0] got, lo, hb);
    compares++;
    if (((got >= lo) && (got <= hb)) !== 1'b1) begin
      errors++;
      $display("ERROR %0t got %h outside %h..%h", $time, got, lo, hb);
    end
  endtask : chkr

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  // Counts high cycles, toggles and channel disagreement over 50 cycles
  task samp;
    logic p;
    hi = 0;
    tg = 0;
    ne = 0;
    repeat (3) @(negedge clk);
    p = cout[0];
    repeat (50) begin
      @(negedge clk);
      hi += (cout[0] === 1'b1);
      tg += (cout[0] !== p);
      ne += (cout[0] !== cout[1]);
      p = cout[0];
    end
  endtask : samp

  task cfg(input logic [2:0] c0, c1, input logic pol);
    wr(TCT_CHCTL_OFS, {2'b01, 1'b0, pol, 5'h00, c1, 4'h0,
                       2'b01, 1'b0, pol, 5'h00, c0, 4'h0});
  endtask : cfg

  task t_reset;
    rd(TCT_CAR_OFS);
    chk(v, 32'h0000FFFF);
    rd(8'h30);
    chk(32'(rs), 32'(TCT_RESP_ERR));
    chk(v, 32'h00000000);
    wr(8'h30, 32'h00000000);
    chk(32'(bs), 32'(TCT_RESP_ERR));
  endtask : t_reset

  task t_count;
    wr(TCT_CAR_OFS, 32'h00000009);
    chk(32'(bs), 32'(TCT_RESP_OK));
    wr(TCT_SWEV_OFS, 32'h00000001);
    wr(TCT_STAT_OFS, 32'h00000000);
    wr(TCT_INTEN_OFS, 32'h00000001);
    wr(TCT_CTL_OFS, 32'h00000001);
    repeat (6) begin
      rd(TCT_CNT_OFS);
      chkr(v, 32'h0, 32'h9);
    end
    rd(TCT_STAT_OFS);
    chk(v & 32'h1, 32'h1);
    chk(32'(uirq), 32'h1);
    wr(TCT_CTL_OFS, 32'h00000003);
    wr(TCT_STAT_OFS, 32'h00000000);
    repeat (30) @(posedge clk);
    rd(TCT_STAT_OFS);
    chk(v & 32'h1, 32'h0);
    wr(TCT_CTL_OFS, 32'h00000000);
    wr(TCT_SWEV_OFS, 32'h00000001);
    repeat (10) @(posedge clk);
    rd(TCT_CNT_OFS);
    chk(v, 32'h0);
    rd(TCT_STAT_OFS);
    chk(v & 32'h1, 32'h1);
  endtask : t_count

  task t_psc;
    wr(TCT_CAR_OFS, 32'h0000FFFF);
    wr(TCT_SWEV_OFS, 32'h00000001);
    wr(TCT_CTL_OFS, 32'h00000001);
    wr(TCT_PSC_OFS, 32'h00000003);
    rd(TCT_CNT_OFS);
    w = v;
    repeat (40) @(posedge clk);
    rd(TCT_CNT_OFS);
    chkr(v - w, 32'd40, 32'd47);
    wr(TCT_SWEV_OFS, 32'h00000001);
    rd(TCT_CNT_OFS);
    w = v;
    repeat (40) @(posedge clk);
    rd(TCT_CNT_OFS);
    chkr(v - w, 32'd9, 32'd12);
  endtask : t_psc

  task t_ext;
    logic [5:0] m, n;
    wr(TCT_PSC_OFS, 32'h00000000);
    wr(TCT_CHCTL_OFS, 32'h00010001);
    for (int t = 0; t < 6; t++) begin
      m = (t < 4) ? 6'h04 << t : 6'(t - 3);
      n = (t < 4) ? 6'h04 << ((t + 1) % 4) : 6'(6 - t);
      wr(TCT_SLV_OFS, 32'h7 | 32'((t < 4 ? t : t + 1) << 4));
      wr(TCT_SWEV_OFS, 32'h00000001);
      repeat (3) src.pulse(m);
      src.pulse(n);
      rd(TCT_CNT_OFS);
      chk(v, 32'h3);
    end
    wr(TCT_SLV_OFS, 32'h00000004);
    rd(TCT_CNT_OFS);
    w = v;
    repeat (20) @(posedge clk);
    rd(TCT_CNT_OFS);
    chkr(v - w, 32'd20, 32'd27);
  endtask : t_ext

  task t_capture;
    int d0;
    d0 = dma0;
    wr(TCT_SLV_OFS, 32'h00000000);
    wr(TCT_CHCTL_OFS, 32'h40024001);
    rd(TCT_CV0_OFS);
    w = v;
    wr(TCT_CV0_OFS, 32'h00001234);
    rd(TCT_CV0_OFS);
    chk(v, w);
    wr(TCT_INTEN_OFS, 32'h00000606);
    wr(TCT_STAT_OFS, 32'h00000000);
    src.pulse(6'h01);
    rd(TCT_STAT_OFS);
    chk(v, 32'h6);
    chk(32'(cirq), 32'h3);
    rd(TCT_CV0_OFS);
    w = v;
    chkr(w, 32'h1, 32'hFFFF);
    rd(TCT_CV1_OFS);
    chk(v, w);
    src.pulse(6'h01);
    rd(TCT_STAT_OFS);
    chk(v, 32'h606);
    chk(dma0 - d0, 32'd2);
    wr(TCT_STAT_OFS, 32'h00000000);
    rd(TCT_STAT_OFS);
    chk(v, 32'h0);
  endtask : t_capture

  task t_swev;
    int d1;
    wr(TCT_CTL_OFS, 32'h00000000);
    wr(TCT_CHCTL_OFS, 32'h00000000);
    d1 = dma1;
    wr(TCT_SWEV_OFS, 32'h00000004);
    rd(TCT_STAT_OFS);
    chk(v, 32'h4);
    chk(32'(cirq), 32'h2);
    chk(dma1 - d1, 32'd1);
  endtask : t_swev

  task t_cmp;
    wr(TCT_CAR_OFS, 32'h00000009);
    wr(TCT_SWEV_OFS, 32'h00000001);
    wr(TCT_CV0_OFS, 32'h00000005);
    wr(TCT_CV1_OFS, 32'h00000005);
    wr(TCT_CTL_OFS, 32'h00000001);
    cfg(TCT_CMP_FLO, TCT_CMP_FLO, 1'b0);
    samp();
    chk(hi, 32'd0);
    chk(32'(coe), 32'h3);
    cfg(TCT_CMP_FHI, TCT_CMP_FHI, 1'b0);
    samp();
    chk(hi, 32'd50);
    cfg(TCT_CMP_FHI, TCT_CMP_FHI, 1'b1);
    samp();
    chk(hi, 32'd0);
    cfg(TCT_CMP_CLR, TCT_CMP_CLR, 1'b0);
    samp();
    chk(32'(cout[0]), 32'h0);
    cfg(TCT_CMP_SET, TCT_CMP_SET, 1'b0);
    samp();
    chk(32'(cout[0]), 32'h1);
    wr(TCT_STAT_OFS, 32'h00000000);
    cfg(TCT_CMP_TGL, TCT_CMP_TGL, 1'b0);
    samp();
    chkr(tg, 32'd4, 32'd6);
    rd(TCT_STAT_OFS);
    chk(v & 32'h2, 32'h2);
    cfg(TCT_CMP_PWM0, TCT_CMP_PWM1, 1'b0);
    samp();
    chk(hi, 32'd25);
    chk(ne, 32'd50);
    wr(TCT_CV0_OFS, 32'h0000000C);
    samp();
    chk(hi, 32'd50);
    wr(TCT_CV0_OFS, 32'h00000000);
    samp();
    chk(hi, 32'd0);
    wr(TCT_CHCTL_OFS, 32'h00000000);
    @(negedge clk);
    chk(32'(coe), 32'h0);
  endtask : t_cmp

  initial begin
    rst = 1'b1;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_count();
    t_psc();
    t_ext();
    t_capture();
    t_swev();
    t_cmp();
    final_report();
  end
endmodule : tb

// ### tct_pkg.sv
// Constants and register map of the two-channel capture/compare timer
// What this block does
// - A 16-bit unsigned counter that only counts upward.
// - Slave mode 0 clocks the prescaler from the internal clock once enabled.
// - Slave modes 1,2,3,7 use the trigger source; 4,5,6 the internal clock.
// - Mode 7 with trigger 4-6: chosen pin edges give one tick each.
// - Mode 7 with trigger 0-3: each rising edge of the chosen internal trigger gives a tick.
// - Prescaler divides by value plus one; new value applies at next update.
// - Counter runs from 0 to auto-reload, wraps, update event on overflow.
// - Update-generate bit clears the counter and makes an update event.
// - Update-disable bit suppresses all update events.
// - Update event loads auto-reload and prescaler shadows from preloads.
// - Input path: synchronise, filter, edge by polarity, source select, prescale.
// - Capture copies counter to channel value, sets flag, raises enabled irq.
// - Nonzero channel mode means input mode; value writes are ignored.
// - Capture while channel flag is set also sets overcapture flag.
// - Channel events raise interrupt and DMA request when enabled.
// - Event-generate bit sets flag, overcapture, irq and DMA like a capture, but copies no counter value.
// - Mode 1 routes own input to capture, mode 2 the other channel input.
// - Compare match sets, clears or toggles output and raises channel event.
// - Compare shadow enable picks immediate or update-time value load.
// - Output polarity follows polarity bit; driven only when channel enabled.
// - Compare control 6 and 7 are PWM modes 0 and 1.
// - PWM mode 0: output always active when value exceeds auto-reload.
// - PWM mode 0: output always inactive when value is zero.
// - Compare control 0-3: hold, set, clear, toggle on match.
// - Compare control 4 and 5 force inactive and active.
package tct_pkg;
  localparam logic [7:0] TCT_CTL_OFS = 8'h00;
  localparam logic [7:0] TCT_SLV_OFS = 8'h04;
  localparam logic [7:0] TCT_INTEN_OFS = 8'h08;
  localparam logic [7:0] TCT_STAT_OFS = 8'h0C;
  localparam logic [7:0] TCT_SWEV_OFS = 8'h10;
  localparam logic [7:0] TCT_CHCTL_OFS = 8'h14;
  localparam logic [7:0] TCT_CNT_OFS = 8'h18;
  localparam logic [7:0] TCT_PSC_OFS = 8'h1C;
  localparam logic [7:0] TCT_CAR_OFS = 8'h20;
  localparam logic [7:0] TCT_CV0_OFS = 8'h24;
  localparam logic [7:0] TCT_CV1_OFS = 8'h28;
  // Control: bit0 counter enable, bit1 update disable
  localparam int TCT_CEN_BIT = 0;
  localparam int TCT_UDIS_BIT = 1;
  // Slave config: [2:0] slave mode, [6:4] trigger source
  localparam int TCT_SMS_LSB = 0;
  localparam int TCT_TRG_LSB = 4;
  // Status/enable/event bits: bit0 update, bit1/2 channel, bit9/10 overcap in status, DMA in enable
  localparam int TCT_UP_BIT = 0;
  localparam int TCT_CH_LSB = 1;
  localparam int TCT_OF_LSB = 9;
  localparam int TCT_DMA_LSB = 9;
  // Channel control per 16-bit half: [1:0] mode, [3] shadow, [6:4] compare,
  // [11:8] filter, [12] polarity, [13] polarity aux, [14] enable, [15:?]
  localparam int TCT_CH_W = 16;
  localparam int TCT_MS_LSB = 0;
  localparam int TCT_SEN_BIT = 3;
  localparam int TCT_CMP_LSB = 4;
  localparam int TCT_FLT_LSB = 8;
  localparam int TCT_POL_BIT = 12;
  localparam int TCT_NPOL_BIT = 13;
  localparam int TCT_EN_BIT = 14;
  localparam int TCT_ICP_LSB = 6;
  localparam logic [1:0] TCT_ICP_W = 2'h2;
  localparam logic [15:0] TCT_CAR_RST = 16'hFFFF;
  localparam logic [2:0] TCT_SMS_INT = 3'h0;
  localparam logic [2:0] TCT_SMS_EXT = 3'h7;
  localparam logic [2:0] TCT_CMP_SET = 3'h1;
  localparam logic [2:0] TCT_CMP_CLR = 3'h2;
  localparam logic [2:0] TCT_CMP_TGL = 3'h3;
  localparam logic [2:0] TCT_CMP_FLO = 3'h4;
  localparam logic [2:0] TCT_CMP_FHI = 3'h5;
  localparam logic [2:0] TCT_CMP_PWM0 = 3'h6;
  localparam logic [2:0] TCT_CMP_PWM1 = 3'h7;
  localparam logic [1:0] TCT_RESP_OK = 2'h0;
  localparam logic [1:0] TCT_RESP_ERR = 2'h2;
endpackage : tct_pkg

// ### tct_src_model.sv
// Model of the channel input pins and internal trigger sources
`timescale 1ns/1ns
module tct_src_model (
  // Clock
  input wire logic clk,
  // Pins and triggers
  output logic [1:0] pin,
  output logic [3:0] trg
);
  initial begin
    pin = 2'h0;
    trg = 4'h0;
  end
  // High pulse on the lines in mask {trg, pin}, held past the filter
  task pulse(input logic [5:0] m);
    @(posedge clk);
    {trg, pin} <= m;
    repeat (4) @(posedge clk);
    {trg, pin} <= 6'h00;
    repeat (4) @(posedge clk);
  endtask : pulse
endmodule : tct_src_model

// ### tct_timer.sv
// Two-channel capture/compare timer with AXI4-Lite register slave
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module tct_timer
  import tct_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel pins and triggers
  input wire logic [1:0] channel_input_pin,
  input wire logic [3:0] internal_trigger_input,
  output logic [1:0] channel_out,
  output logic [1:0] channel_out_en,
  // Requests
  output logic [1:0] channel_irq,
  output logic update_irq,
  output logic [1:0] channel_dma_req
);
  logic [1:0] ctl_q;
  logic [6:0] slv_q;
  logic [10:0] inten_q;
  logic [10:0] stat_q;
  logic [31:0] chctl_q;
  logic [CNT_W-1:0] cnt_q, psc_pre_q, psc_sh_q, psc_cnt_q;
  logic [CNT_W-1:0] car_pre_q, car_sh_q;
  logic [CNT_W-1:0] cv_q [2];
  logic [CNT_W-1:0] cvsh_q [2];
  // Bus write holding
  logic aw_have_q, w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wr_go;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCT_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > TCT_CV1_OFS || awaddr_q[1:0] != 2'h0) ?
                       TCT_RESP_ERR : TCT_RESP_OK;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_go && awaddr_q == ofs;
  endfunction : wr_at
  // Write data lands per byte lane; unstrobed low lanes write zero, unstrobed chctl upper lanes keep their value
  logic [3:0] wstrb_q;
  always_ff @(posedge clk) begin
    if (rst)
      wstrb_q <= 4'h0;
    else if (s_axi_wvalid && s_axi_wready)
      wstrb_q <= s_axi_wstrb;
  end
  logic [15:0] wd;
  assign wd = {wstrb_q[1] ? wdata_q[15:8] : 8'h00,
               wstrb_q[0] ? wdata_q[7:0] : 8'h00};
  // Simple control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_q <= 2'h0;
      slv_q <= 7'h00;
      inten_q <= 11'h000;
      chctl_q <= 32'h0000_0000;
      psc_pre_q <= '0;
      car_pre_q <= TCT_CAR_RST;
    end else begin
      if (wr_at(TCT_CTL_OFS)) ctl_q <= wd[1:0];
      if (wr_at(TCT_SLV_OFS)) slv_q <= wd[6:0];
      if (wr_at(TCT_INTEN_OFS)) inten_q <= wd[10:0];
      if (wr_at(TCT_CHCTL_OFS)) chctl_q <= {
        wstrb_q[3] ? wdata_q[31:24] : chctl_q[31:24],
        wstrb_q[2] ? wdata_q[23:16] : chctl_q[23:16], wd};
      if (wr_at(TCT_PSC_OFS)) psc_pre_q <= wd;
      if (wr_at(TCT_CAR_OFS)) car_pre_q <= wd;
    end
  end
  // Clock source selection
  logic [2:0] sms, trg;
  assign sms = slv_q[TCT_SMS_LSB +: 3];
  assign trg = slv_q[TCT_TRG_LSB +: 3];
  logic [3:0] iti_q;
  logic [1:0] edge_ev;
  always_ff @(posedge clk) begin
    if (rst) iti_q <= 4'h0;
    else iti_q <= internal_trigger_input;
  end
  logic ext_tick, tick;
  always_comb begin
    ext_tick = 1'b0;
    if (!trg[2])
      ext_tick = internal_trigger_input[trg[1:0]] && !iti_q[trg[1:0]];
    else if (trg == 3'h4)
      ext_tick = edge_ev[0];
    else if (trg == 3'h5)
      ext_tick = edge_ev[0];
    else if (trg == 3'h6)
      ext_tick = edge_ev[1];
  end
  always_comb begin
    tick = 1'b1;
    if (sms == 3'h1 || sms == 3'h2 || sms == 3'h3 || sms == TCT_SMS_EXT)
      tick = ext_tick;
  end
  // Counter, prescaler and update events
  logic run, psc_ev, ovf, ug, upd;
  assign run = ctl_q[TCT_CEN_BIT];
  assign psc_ev = run && tick && psc_cnt_q == psc_sh_q;
  assign ovf = psc_ev && cnt_q >= car_sh_q;
  assign ug = wr_at(TCT_SWEV_OFS) && wd[TCT_UP_BIT];
  assign upd = (ovf || ug) && !ctl_q[TCT_UDIS_BIT];
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      psc_cnt_q <= '0;
      psc_sh_q <= '0;
      car_sh_q <= TCT_CAR_RST;
    end else begin
      if (ug) begin
        cnt_q <= '0;
        psc_cnt_q <= '0;
      end else if (run && tick) begin
        psc_cnt_q <= psc_ev ? '0 : psc_cnt_q + 1'b1;
        if (psc_ev) cnt_q <= ovf ? '0 : cnt_q + 1'b1;
      end
      if (upd) begin
        psc_sh_q <= psc_pre_q;
        car_sh_q <= car_pre_q;
      end
    end
  end
  // Channel input stage
  logic [1:0] sync1_q, sync2_q, filt_q, prev_q;
  logic [3:0] fcnt_q [2];
  logic [2:0] icp_q [2];
  logic [1:0] cap_ev, cmp_ev, sw_ev, ch_ev;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= channel_input_pin;
      sync2_q <= sync1_q;
    end
  end
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [15:0] cc;
    logic [1:0] ms;
    logic [2:0] cmc;
    logic sel, hit, act;
    assign cc = chctl_q[i*TCT_CH_W +: TCT_CH_W];
    assign ms = cc[TCT_MS_LSB +: 2];
    assign cmc = cc[TCT_CMP_LSB +: 3];
    // Filter: input must stay stable for the programmed count plus one cycles
    always_ff @(posedge clk) begin
      if (rst) begin
        fcnt_q[i] <= 4'h0;
        filt_q[i] <= 1'b0;
        prev_q[i] <= 1'b0;
      end else begin
        prev_q[i] <= filt_q[i];
        if (sync2_q[i] == filt_q[i]) fcnt_q[i] <= 4'h0;
        else if (fcnt_q[i] >= cc[TCT_FLT_LSB +: 4]) begin
          filt_q[i] <= sync2_q[i];
          fcnt_q[i] <= 4'h0;
        end else fcnt_q[i] <= fcnt_q[i] + 4'h1;
      end
    end
    // Edge selected by polarity bits, both bits give either edge
    assign edge_ev[i] = (filt_q[i] != prev_q[i]) &&
      ((cc[TCT_POL_BIT] && cc[TCT_NPOL_BIT]) ||
       (filt_q[i] ^ cc[TCT_POL_BIT]));
    assign sel = (ms == 2'h1) ? edge_ev[i] :
                 (ms == 2'h2) ? edge_ev[1-i] : 1'b0;
    // Input prescaler: 1, 2, 4 or 8 events per capture
    always_ff @(posedge clk) begin
      if (rst) icp_q[i] <= 3'h0;
      else if (sel) icp_q[i] <= (icp_q[i] ==
        3'((1 << cc[TCT_ICP_LSB +: TCT_ICP_W]) - 1)) ? 3'h0 : icp_q[i] + 3'h1;
    end
    assign cap_ev[i] = sel && cc[TCT_EN_BIT] && icp_q[i] ==
      3'((1 << cc[TCT_ICP_LSB +: TCT_ICP_W]) - 1);
    // Channel value, shadow and compare
    always_ff @(posedge clk) begin
      if (rst) begin
        cv_q[i] <= '0;
        cvsh_q[i] <= '0;
      end else begin
        if (ms != 2'h0) begin
          if (cap_ev[i]) cv_q[i] <= cnt_q;
        end else if (wr_at(i ? TCT_CV1_OFS : TCT_CV0_OFS)) begin
          cv_q[i] <= wd;
        end
        if (!cc[TCT_SEN_BIT] || upd) cvsh_q[i] <= cv_q[i];
      end
    end
    assign hit = ms == 2'h0 && psc_ev && cnt_q == cvsh_q[i];
    assign cmp_ev[i] = hit;
    always_ff @(posedge clk) begin
      if (rst) act <= 1'b0;
      else unique case (cmc)
        3'h0: act <= act;
        TCT_CMP_SET: if (hit) act <= 1'b1;
        TCT_CMP_CLR: if (hit) act <= 1'b0;
        TCT_CMP_TGL: if (hit) act <= !act;
        TCT_CMP_FLO: act <= 1'b0;
        TCT_CMP_FHI: act <= 1'b1;
        TCT_CMP_PWM0: act <= cnt_q < cvsh_q[i];
        TCT_CMP_PWM1: act <= !(cnt_q < cvsh_q[i]);
      endcase
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        channel_out[i] <= 1'b0;
        channel_out_en[i] <= 1'b0;
      end else begin
        channel_out[i] <= act ^ cc[TCT_POL_BIT];
        channel_out_en[i] <= cc[TCT_EN_BIT] && ms == 2'h0;
      end
    end
    assign sw_ev[i] = wr_at(TCT_SWEV_OFS) && wd[TCT_CH_LSB + i];
    assign ch_ev[i] = cap_ev[i] || cmp_ev[i] || sw_ev[i];
  end
  // Status flags: set wins over a clear in the same cycle
  logic [10:0] set_v, clr_v;
  always_comb begin
    set_v = 11'h000;
    set_v[TCT_UP_BIT] = upd;
    set_v[TCT_CH_LSB +: 2] = ch_ev;
    set_v[TCT_OF_LSB +: 2] = (cap_ev | sw_ev) &
      stat_q[TCT_CH_LSB +: 2];
    clr_v = wr_at(TCT_STAT_OFS) ? ~wd[10:0] : 11'h000;
  end
  always_ff @(posedge clk) begin
    if (rst) stat_q <= 11'h000;
    else stat_q <= (stat_q & ~clr_v) | set_v;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_irq <= 2'h0;
      update_irq <= 1'b0;
      channel_dma_req <= 2'h0;
    end else begin
      channel_irq <= stat_q[TCT_CH_LSB +: 2] & inten_q[TCT_CH_LSB +: 2];
      update_irq <= stat_q[TCT_UP_BIT] & inten_q[TCT_UP_BIT];
      channel_dma_req <= ch_ev & inten_q[TCT_DMA_LSB +: 2];
    end
  end
  // Read channel
  logic [31:0] rd;
  always_comb begin
    unique case (s_axi_araddr)
      TCT_CTL_OFS: rd = {30'h0, ctl_q};
      TCT_SLV_OFS: rd = {25'h0, slv_q};
      TCT_INTEN_OFS: rd = {21'h0, inten_q};
      TCT_STAT_OFS: rd = {21'h0, stat_q};
      TCT_CHCTL_OFS: rd = chctl_q;
      TCT_CNT_OFS: rd = {16'h0, cnt_q};
      TCT_PSC_OFS: rd = {16'h0, psc_pre_q};
      TCT_CAR_OFS: rd = {16'h0, car_pre_q};
      TCT_CV0_OFS: rd = {16'h0, cv_q[0]};
      TCT_CV1_OFS: rd = {16'h0, cv_q[1]};
      default: rd = 32'h0000_0000;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TCT_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= (s_axi_araddr > TCT_CV1_OFS || s_axi_araddr[1:0] != 2'h0)
                     ? TCT_RESP_ERR : TCT_RESP_OK;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // Checks
  capture_copy_a: assert property (@(posedge clk) disable iff (rst)
    cap_ev[0] |=> cv_q[0] == $past(cnt_q) && stat_q[TCT_CH_LSB])
    else $error("capture did not copy counter");
  overcap_a: assert property (@(posedge clk) disable iff (rst)
    cap_ev[0] && stat_q[TCT_CH_LSB] |=> stat_q[TCT_OF_LSB])
    else $error("overcapture flag missing");
  wrap_zero_a: assert property (@(posedge clk) disable iff (rst)
    ovf && !ug |=> cnt_q == '0)
    else $error("counter did not wrap");
  ug_clear_a: assert property (@(posedge clk) disable iff (rst)
    ug |=> cnt_q == '0)
    else $error("update generate did not clear counter");
  udis_quiet_a: assert property (@(posedge clk) disable iff (rst)
    ctl_q[TCT_UDIS_BIT] |-> !upd)
    else $error("update with disable set");
  shadow_load_a: assert property (@(posedge clk) disable iff (rst)
    upd |=> car_sh_q == $past(car_pre_q) && psc_sh_q == $past(psc_pre_q))
    else $error("shadows not loaded");
  input_nowrite_a: assert property (@(posedge clk) disable iff (rst)
    g_ch[0].ms != 2'h0 && !cap_ev[0] |=> $stable(cv_q[0]))
    else $error("input channel value changed");
  flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
    stat_q[TCT_CH_LSB] && !wr_at(TCT_STAT_OFS) |=> stat_q[TCT_CH_LSB])
    else $error("channel flag dropped");
  sw_event_a: assert property (@(posedge clk) disable iff (rst)
    sw_ev[1] && inten_q[TCT_DMA_LSB + 1] |=> channel_dma_req[1])
    else $error("software event gave no dma");
endmodule : tct_timer
